// >>> hdl/fmd_datapath.sv
// Fixed point multiply-accumulate datapath, top module
//
// Behaviour
// - Four 24-bit input registers exist, an x pair and a y pair, each high and low.
// - Two 56-bit accumulators are each built from three part registers and feed a shifter.
// - Every register is read and written from either the x or the y bus as 16 or 24 bits, except the extension parts, written from the low 8 bus bits.
// - Sources are 24, 48 or 56 bits wide, or 16, 16 or 24 significant bits in 16-bit mode.
// - Operation sources come only from the datapath registers.
// - Every operation result goes into one of the two accumulators.
// - An operation takes two cycles in a pipeline and one may start every cycle.
// - The multiply-accumulate takes up to three operands and gives one 56-bit result.
// - The multiplier does 24 by 24 fractional products, signed, unsigned or mixed.
// - The 48-bit product is shifted left one bit for fractional alignment and added to the whole 56-bit accumulator.
// - The low product part is kept, or rounded into the high part and cleared when asked.
// - A mode input picks 24-bit or 16-bit precision.
// - A 56-bit barrel shifter performs shifts for the bit field operations.
// - Two limiters condition accumulator values read out onto the x and y buses.
`timescale 1ns/1ps
`include "fmd_map.svh"
module fmd_datapath (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mode16_i,
    input wire fmd_pkg::fmd_op_t op_i,
    input wire fmd_pkg::fmd_bus_wr_t xw_i,
    input wire fmd_pkg::fmd_bus_wr_t yw_i,
    input wire fmd_pkg::fmd_reg_t x_rd_sel_i,
    input wire fmd_pkg::fmd_reg_t y_rd_sel_i,
    output logic [`FMD_DW-1:0] x_rdata_o,
    output logic [`FMD_DW-1:0] y_rdata_o,
    output logic x_lim_o,
    output logic y_lim_o,
    output logic res_valid_o
);
    // ************************************************
    // Storage
    // ************************************************
    logic [`FMD_DW-1:0] in_ff [4];
    fmd_pkg::fmd_acc_t acc_ff [2];
    fmd_pkg::fmd_acc_t nxt_acc [2];
    fmd_pkg::fmd_stage_t s1_ff;
    fmd_pkg::fmd_stage_t nxt_s1;
    logic mode16_ff;

    // ************************************************
    // Functions
    // ************************************************
    // Keeps the 16 significant bits of a word in 16-bit mode
    function automatic logic [`FMD_DW-1:0] prec(input logic [`FMD_DW-1:0] w, input logic m16);
        prec = m16 ? (w & `FMD_MASK16) : w;
    endfunction

    // Bus data into a 24-bit register
    function automatic logic [`FMD_DW-1:0] from_bus(input logic [`FMD_DW-1:0] d, input logic m16);
        from_bus = m16 ? {d[`FMD_HW-1:0], `FMD_ZPAD8} : d;
    endfunction

    // Source operand, aligned to the 56-bit accumulator format
    // Registers as arguments: a continuous assignment only tracks its operands
    function automatic logic [`FMD_AW-1:0] src_val(input fmd_pkg::fmd_src_t s, input logic m16,
            input logic [`FMD_DW-1:0] xh, input logic [`FMD_DW-1:0] xl, input logic [`FMD_DW-1:0] yh,
            input logic [`FMD_DW-1:0] yl, input fmd_pkg::fmd_acc_t a, input fmd_pkg::fmd_acc_t b);
        logic [`FMD_DW-1:0] hi;
        logic [`FMD_DW-1:0] lo;
        hi = '0;
        lo = '0;
        src_val = '0;
        case (s)
            fmd_pkg::SRC_XH: hi = xh;
            fmd_pkg::SRC_XL: hi = xl;
            fmd_pkg::SRC_YH: hi = yh;
            fmd_pkg::SRC_YL: hi = yl;
            fmd_pkg::SRC_X: begin
                hi = xh;
                lo = xl;
            end
            fmd_pkg::SRC_Y: begin
                hi = yh;
                lo = yl;
            end
            default: ;
        endcase
        case (s)
            fmd_pkg::SRC_A: src_val = a;
            fmd_pkg::SRC_B: src_val = b;
            default: src_val = {{`FMD_EW{hi[`FMD_DW-1]}}, prec(hi, m16), prec(lo, m16)};
        endcase
        if (m16) begin
            src_val = src_val & `FMD_TRUNC16;
        end
    endfunction

    // Limiter: saturates when the extension holds significant bits
    function automatic logic [`FMD_DW:0] limit(input fmd_pkg::fmd_acc_t a, input logic m16);
        logic ovf;
        ovf = (a.extension_part != {`FMD_EW{a.high_product[`FMD_DW-1]}});
        if (!ovf) begin
            limit = {1'b0, m16 ? {`FMD_ZPAD8, a.high_product[`FMD_DW-1:`FMD_EW]} : a.high_product};
        end else if (a.extension_part[`FMD_EW-1]) begin
            limit = {1'b1, m16 ? `FMD_LIM_NEG16 : `FMD_LIM_NEG24};
        end else begin
            limit = {1'b1, m16 ? `FMD_LIM_POS16 : `FMD_LIM_POS24};
        end
    endfunction

    // Register read onto a bus
    function automatic logic [`FMD_DW:0] rd_val(input fmd_pkg::fmd_reg_t s, input logic m16,
            input logic [`FMD_DW-1:0] xh, input logic [`FMD_DW-1:0] xl, input logic [`FMD_DW-1:0] yh,
            input logic [`FMD_DW-1:0] yl, input fmd_pkg::fmd_acc_t a, input fmd_pkg::fmd_acc_t b);
        logic [`FMD_DW-1:0] w;
        w = '0;
        rd_val = '0;
        case (s)
            fmd_pkg::REG_X_HIGH: w = xh;
            fmd_pkg::REG_X_LOW: w = xl;
            fmd_pkg::REG_Y_HIGH: w = yh;
            fmd_pkg::REG_Y_LOW: w = yl;
            fmd_pkg::REG_A_EXT: w = {{`FMD_HW{a.extension_part[`FMD_EW-1]}}, a.extension_part};
            fmd_pkg::REG_A_MSP: w = a.high_product;
            fmd_pkg::REG_A_LSP: w = a.low_product;
            fmd_pkg::REG_B_EXT: w = {{`FMD_HW{b.extension_part[`FMD_EW-1]}}, b.extension_part};
            fmd_pkg::REG_B_MSP: w = b.high_product;
            fmd_pkg::REG_B_LSP: w = b.low_product;
            default: w = '0;
        endcase
        case (s)
            fmd_pkg::REG_ACC_A: rd_val = limit(a, m16);
            fmd_pkg::REG_ACC_B: rd_val = limit(b, m16);
            default: rd_val = {1'b0, m16 ? {`FMD_ZPAD8, w[`FMD_DW-1:`FMD_EW]} : w};
        endcase
    endfunction

    // ************************************************
    // Stage one: operand fetch and multiply
    // ************************************************
    wire logic [`FMD_AW-1:0] opnd1 = src_val(op_i.src1, mode16_ff, in_ff[0], in_ff[1], in_ff[2], in_ff[3],
        acc_ff[0], acc_ff[1]);
    wire logic [`FMD_AW-1:0] opnd2 = src_val(op_i.src2, mode16_ff, in_ff[0], in_ff[1], in_ff[2], in_ff[3],
        acc_ff[0], acc_ff[1]);
    wire logic [`FMD_DW-1:0] mul_a = opnd1[`FMD_PW-1:`FMD_DW];
    wire logic [`FMD_DW-1:0] mul_b = opnd2[`FMD_PW-1:`FMD_DW];
    wire logic a_sgn = (op_i.sgn != fmd_pkg::SGN_UU) & mul_a[`FMD_DW-1];
    wire logic b_sgn = (op_i.sgn == fmd_pkg::SGN_SS) & mul_b[`FMD_DW-1];
    wire logic signed [2*`FMD_DW+1:0] raw = $signed({a_sgn, mul_a}) * $signed({b_sgn, mul_b});
    // Fractional alignment; unsigned products may carry into the extension
    wire logic p_sgn = raw[2*`FMD_DW+1];
    wire logic [`FMD_AW-1:0] prod56 = {{(`FMD_AW-2*`FMD_DW-2){p_sgn}}, raw[2*`FMD_DW:0], 1'b0};

    always_comb begin
        nxt_s1 = '0;
        nxt_s1.valid = op_i.valid && (op_i.opc != fmd_pkg::OPC_NOP);
        nxt_s1.opc = op_i.opc;
        nxt_s1.dest_b = op_i.dest_b;
        nxt_s1.round = op_i.round;
        nxt_s1.shamt = op_i.shamt;
        nxt_s1.prod = prod56;
        nxt_s1.opnd = opnd1;
    end

    // ************************************************
    // Stage two: accumulate, shift, round
    // ************************************************
    wire logic [`FMD_AW-1:0] acc_cur = s1_ff.dest_b ? acc_ff[1] : acc_ff[0];
    wire logic [`FMD_AW-1:0] shifted;

    fmd_shift u_shift (
        .data_i(s1_ff.opnd),
        .amt_i(s1_ff.shamt),
        .arith_i(s1_ff.opc == fmd_pkg::OPC_ASH),
        .data_o(shifted)
    );

    logic [`FMD_AW-1:0] res;
    always_comb begin
        case (s1_ff.opc)
            fmd_pkg::OPC_MPY: res = s1_ff.prod;
            fmd_pkg::OPC_MAC: res = acc_cur + s1_ff.prod;
            fmd_pkg::OPC_MACN: res = acc_cur - s1_ff.prod;
            fmd_pkg::OPC_ADD: res = acc_cur + s1_ff.opnd;
            fmd_pkg::OPC_SUB: res = acc_cur - s1_ff.opnd;
            fmd_pkg::OPC_TFR: res = s1_ff.opnd;
            fmd_pkg::OPC_AND: res = acc_cur & s1_ff.opnd;
            fmd_pkg::OPC_OR: res = acc_cur | s1_ff.opnd;
            fmd_pkg::OPC_ASH: res = shifted;
            fmd_pkg::OPC_LSH: res = shifted;
            default: res = `FMD_ZERO56;
        endcase
    end

    wire logic [`FMD_AW-1:0] rnd_add = mode16_ff ? `FMD_RND16 : `FMD_RND24;
    wire logic [`FMD_AW-1:0] rnd_mask = mode16_ff ? `FMD_TRUNC16 : `FMD_TRUNC24;
    wire logic [`FMD_AW-1:0] res_fin = s1_ff.round ? ((res + rnd_add) & rnd_mask) : res;

    // ************************************************
    // Accumulator update
    // ************************************************
    always_comb begin
        fmd_pkg::fmd_bus_wr_t bw;
        bw = '0;
        nxt_acc[0] = acc_ff[0];
        nxt_acc[1] = acc_ff[1];
        // Y bus first so the X bus wins a same-register clash
        for (int w = 0; w < 2; w++) begin
            bw = (w == 0) ? yw_i : xw_i;
            if (bw.en) begin
                case (bw.sel)
                    fmd_pkg::REG_A_EXT: nxt_acc[0].extension_part = bw.data[`FMD_EW-1:0];
                    fmd_pkg::REG_A_MSP: nxt_acc[0].high_product = from_bus(bw.data, mode16_ff);
                    fmd_pkg::REG_A_LSP: nxt_acc[0].low_product = from_bus(bw.data, mode16_ff);
                    fmd_pkg::REG_B_EXT: nxt_acc[1].extension_part = bw.data[`FMD_EW-1:0];
                    fmd_pkg::REG_B_MSP: nxt_acc[1].high_product = from_bus(bw.data, mode16_ff);
                    fmd_pkg::REG_B_LSP: nxt_acc[1].low_product = from_bus(bw.data, mode16_ff);
                    default: ;
                endcase
            end
        end
        // Operation result overrides a bus write to its destination accumulator in the same cycle
        if (s1_ff.valid) begin
            nxt_acc[s1_ff.dest_b] = res_fin;
        end
    end

    // ************************************************
    // Registers
    // ************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_in
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    in_ff[gi] <= '0;
                end else if (xw_i.en && (xw_i.sel == fmd_pkg::fmd_reg_t'(gi))) begin
                    in_ff[gi] <= from_bus(xw_i.data, mode16_ff);
                end else if (yw_i.en && (yw_i.sel == fmd_pkg::fmd_reg_t'(gi))) begin
                    in_ff[gi] <= from_bus(yw_i.data, mode16_ff);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_ff[0] <= '0;
            acc_ff[1] <= '0;
            s1_ff <= '0;
            mode16_ff <= 1'b0;
            res_valid_o <= 1'b0;
        end else begin
            acc_ff[0] <= nxt_acc[0];
            acc_ff[1] <= nxt_acc[1];
            s1_ff <= nxt_s1;
            mode16_ff <= mode16_i;
            res_valid_o <= s1_ff.valid;
        end
    end

    wire logic [`FMD_DW:0] x_rd = rd_val(x_rd_sel_i, mode16_ff, in_ff[0], in_ff[1], in_ff[2], in_ff[3],
        acc_ff[0], acc_ff[1]);
    wire logic [`FMD_DW:0] y_rd = rd_val(y_rd_sel_i, mode16_ff, in_ff[0], in_ff[1], in_ff[2], in_ff[3],
        acc_ff[0], acc_ff[1]);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            x_rdata_o <= '0;
            y_rdata_o <= '0;
            x_lim_o <= 1'b0;
            y_lim_o <= 1'b0;
        end else begin
            x_rdata_o <= x_rd[`FMD_DW-1:0];
            y_rdata_o <= y_rd[`FMD_DW-1:0];
            x_lim_o <= x_rd[`FMD_DW];
            y_lim_o <= y_rd[`FMD_DW];
        end
    end
endmodule

// >>> hdl/fmd_map.svh
// Constants of the fixed point multiply-accumulate datapath
`ifndef FMD_MAP_SVH
`define FMD_MAP_SVH
`define FMD_DW 24
`define FMD_HW 16
`define FMD_EW 8
`define FMD_PW 48
`define FMD_AW 56
`define FMD_SHW 7
`define FMD_ZERO56 56'h00_0000_0000_0000
`define FMD_RND24 56'h00_0000_0080_0000
`define FMD_RND16 56'h00_0000_8000_0000
`define FMD_TRUNC24 56'hFF_FFFF_FF00_0000
`define FMD_TRUNC16 56'hFF_FFFF_0000_0000
`define FMD_MASK16 24'hFF_FF00
`define FMD_ZPAD8 8'h00
`define FMD_LIM_POS24 24'h7F_FFFF
`define FMD_LIM_NEG24 24'h80_0000
`define FMD_LIM_POS16 24'h00_7FFF
`define FMD_LIM_NEG16 24'h00_8000
`endif

// >>> hdl/fmd_pkg.sv
// Types of the fixed point multiply-accumulate datapath
`include "fmd_map.svh"
package fmd_pkg;
    typedef enum logic [3:0] {
        REG_X_HIGH = 4'h0, REG_X_LOW = 4'h1, REG_Y_HIGH = 4'h2, REG_Y_LOW = 4'h3,
        REG_A_EXT = 4'h4, REG_A_MSP = 4'h5, REG_A_LSP = 4'h6,
        REG_B_EXT = 4'h7, REG_B_MSP = 4'h8, REG_B_LSP = 4'h9,
        REG_ACC_A = 4'hA, REG_ACC_B = 4'hB
    } fmd_reg_t;
    typedef enum logic [3:0] {
        OPC_NOP = 4'h0, OPC_MPY = 4'h1, OPC_MAC = 4'h2, OPC_MACN = 4'h3,
        OPC_ADD = 4'h4, OPC_SUB = 4'h5, OPC_TFR = 4'h6, OPC_AND = 4'h7,
        OPC_OR = 4'h8, OPC_ASH = 4'h9, OPC_LSH = 4'hA, OPC_CLR = 4'hB
    } fmd_opc_t;
    typedef enum logic [2:0] {
        SRC_XH = 3'h0, SRC_XL = 3'h1, SRC_YH = 3'h2, SRC_YL = 3'h3,
        SRC_X = 3'h4, SRC_Y = 3'h5, SRC_A = 3'h6, SRC_B = 3'h7
    } fmd_src_t;
    typedef enum logic [1:0] {
        SGN_SS = 2'h0, SGN_SU = 2'h1, SGN_UU = 2'h2
    } fmd_sgn_t;
    typedef struct packed {
        logic en;
        fmd_reg_t sel;
        logic [`FMD_DW-1:0] data;
    } fmd_bus_wr_t;
    typedef struct packed {
        logic valid;
        fmd_opc_t opc;
        fmd_src_t src1;
        fmd_src_t src2;
        logic dest_b;
        fmd_sgn_t sgn;
        logic round;
        logic signed [`FMD_SHW-1:0] shamt;
    } fmd_op_t;
    typedef struct packed {
        logic [`FMD_EW-1:0] extension_part;
        logic [`FMD_DW-1:0] high_product;
        logic [`FMD_DW-1:0] low_product;
    } fmd_acc_t;
    typedef struct packed {
        logic valid;
        fmd_opc_t opc;
        logic dest_b;
        logic round;
        logic signed [`FMD_SHW-1:0] shamt;
        logic [`FMD_AW-1:0] prod;
        logic [`FMD_AW-1:0] opnd;
    } fmd_stage_t;
endpackage

// >>> hdl/fmd_shift.sv
// 56-bit barrel shifter of the bit field unit
`timescale 1ns/1ps
`include "fmd_map.svh"
module fmd_shift (
    input wire logic [`FMD_AW-1:0] data_i,
    input wire logic signed [`FMD_SHW-1:0] amt_i,
    input wire logic arith_i,
    output logic [`FMD_AW-1:0] data_o
);
    wire logic neg = amt_i[`FMD_SHW-1];
    wire logic [`FMD_SHW-1:0] mag = neg ? -amt_i : amt_i;
    wire logic [`FMD_AW-1:0] left = data_i << mag;
    wire logic [`FMD_AW-1:0] right_a = $signed(data_i) >>> mag;
    wire logic [`FMD_AW-1:0] right_l = data_i >> mag;
    // Positive amount shifts left, negative shifts right
    assign data_o = !neg ? left : (arith_i ? right_a : right_l);
endmodule

// >>> bench/fmd_datapath_checker.sv
// Port assertions for the datapath
`timescale 1ns/1ps
`include "fmd_map.svh"
module fmd_datapath_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mode16_i,
    input wire fmd_pkg::fmd_op_t op_i,
    input wire fmd_pkg::fmd_bus_wr_t xw_i,
    input wire fmd_pkg::fmd_bus_wr_t yw_i,
    input wire fmd_pkg::fmd_reg_t x_rd_sel_i,
    input wire fmd_pkg::fmd_reg_t y_rd_sel_i,
    input wire logic [`FMD_DW-1:0] x_rdata_o,
    input wire logic [`FMD_DW-1:0] y_rdata_o,
    input wire logic x_lim_o,
    input wire logic y_lim_o,
    input wire logic res_valid_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic op_go = op_i.valid && (op_i.opc != fmd_pkg::OPC_NOP);
    wire logic x_acc = (x_rd_sel_i == fmd_pkg::REG_ACC_A) || (x_rd_sel_i == fmd_pkg::REG_ACC_B);
    wire logic y_acc = (y_rd_sel_i == fmd_pkg::REG_ACC_A) || (y_rd_sel_i == fmd_pkg::REG_ACC_B);
    wire logic xw_hit = xw_i.en && (xw_i.sel == fmd_pkg::REG_X_HIGH);
    wire logic any_hit = xw_hit || (yw_i.en && (yw_i.sel == fmd_pkg::REG_X_HIGH));
    property p_res_cause;
        res_valid_o |-> $past(op_go, 2);
    endproperty
    a_res_cause: assert property (p_res_cause) else $error("result pulse without operation");
    property p_res_lat;
        op_go |-> ##2 res_valid_o;
    endproperty
    a_res_lat: assert property (p_res_lat) else $error("result pulse missing");
    property p_xlim_src;
        x_lim_o |-> $past(x_acc);
    endproperty
    a_xlim_src: assert property (p_xlim_src) else $error("x limit on part read");
    property p_ylim_src;
        y_lim_o |-> $past(y_acc);
    endproperty
    a_ylim_src: assert property (p_ylim_src) else $error("y limit on part read");
    property p_lim_val;
        x_lim_o |-> x_rdata_o inside {`FMD_LIM_POS24, `FMD_LIM_NEG24, `FMD_LIM_POS16, `FMD_LIM_NEG16};
    endproperty
    a_lim_val: assert property (p_lim_val) else $error("limited value wrong");
    property p_same;
        $past(x_rd_sel_i) == $past(y_rd_sel_i) |-> x_rdata_o == y_rdata_o && x_lim_o == y_lim_o;
    endproperty
    a_same: assert property (p_same) else $error("x and y reads differ");
    property p_m16;
        $past(mode16_i, 2) |-> x_rdata_o[23:16] == 8'h00;
    endproperty
    a_m16: assert property (p_m16) else $error("upper byte set in short mode");
    property p_wr_rd;
        $past(xw_hit, 2) && !$past(any_hit) && !$past(mode16_i, 2) && !$past(mode16_i, 3)
            && $past(x_rd_sel_i) == fmd_pkg::REG_X_HIGH |-> x_rdata_o == $past(xw_i.data, 2);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("written value not read back");
endmodule
bind fmd_datapath fmd_datapath_checker u_chk (.clk_i, .rst_i, .mode16_i, .op_i, .xw_i, .yw_i,
    .x_rd_sel_i, .y_rd_sel_i, .x_rdata_o, .y_rdata_o, .x_lim_o, .y_lim_o, .res_valid_o);

// >>> bench/fmd_core_model.sv
// Core side model: decoder and data bus writers
`timescale 1ns/1ps
module fmd_core_model (
    input wire logic clk_i,
    output logic mode16_o,
    output fmd_pkg::fmd_op_t op_o,
    output fmd_pkg::fmd_bus_wr_t xw_o,
    output fmd_pkg::fmd_bus_wr_t yw_o
);
    initial begin
        mode16_o = 1'b0;
        op_o = '0;
        xw_o = '0;
        yw_o = '0;
    end
    task automatic set_mode(input logic m);
        @(negedge clk_i);
        mode16_o = m;
    endtask
    // Released bus shows inverted data
    task automatic wr(input logic y, input logic [3:0] s, input logic [23:0] d);
        @(negedge clk_i);
        if (y) begin
            yw_o = '{1'b1, fmd_pkg::fmd_reg_t'(s), d};
        end else begin
            xw_o = '{1'b1, fmd_pkg::fmd_reg_t'(s), d};
        end
        @(negedge clk_i);
        xw_o = '{1'b0, fmd_pkg::fmd_reg_t'(s), ~d};
        yw_o = '{1'b0, fmd_pkg::fmd_reg_t'(s), ~d};
    endtask
    task automatic op(input logic [3:0] c, input logic [2:0] s, input logic b, input logic [1:0] g,
            input logic r, input logic [6:0] sh, input logic hold);
        @(negedge clk_i);
        op_o = '{1'b1, fmd_pkg::fmd_opc_t'(c), fmd_pkg::fmd_src_t'(s), fmd_pkg::SRC_YH, b,
            fmd_pkg::fmd_sgn_t'(g), r, sh};
        if (!hold) begin
            @(negedge clk_i);
            op_o.valid = 1'b0;
        end
    endtask
endmodule

// >>> bench/fmd_datapath_tb.sv
// Self-checking bench of the datapath
`timescale 1ns/1ps
module fmd_datapath_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    fmd_pkg::fmd_reg_t x_rd_sel_i = fmd_pkg::REG_X_HIGH;
    fmd_pkg::fmd_reg_t y_rd_sel_i = fmd_pkg::REG_X_HIGH;
    logic mode16_i;
    fmd_pkg::fmd_op_t op_i;
    fmd_pkg::fmd_bus_wr_t xw_i;
    fmd_pkg::fmd_bus_wr_t yw_i;
    logic [23:0] x_rdata_o;
    logic [23:0] y_rdata_o;
    logic x_lim_o;
    logic y_lim_o;
    logic res_valid_o;
    int err_count = 0;
    int n_tests = 0;
    always #25 clk_i = ~clk_i;
    fmd_core_model u_core (.clk_i, .mode16_o(mode16_i), .op_o(op_i), .xw_o(xw_i), .yw_o(yw_i));
    fmd_datapath u_dut (.clk_i, .rst_i, .mode16_i, .op_i, .xw_i, .yw_i, .x_rd_sel_i, .y_rd_sel_i,
        .x_rdata_o, .y_rdata_o, .x_lim_o, .y_lim_o, .res_valid_o);
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic chk(input logic [24:0] seen, input logic [24:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [3:0] s, input logic [23:0] e, input logic l);
        x_rd_sel_i = fmd_pkg::fmd_reg_t'(s);
        y_rd_sel_i = fmd_pkg::fmd_reg_t'(s);
        repeat (2) @(negedge clk_i);
        chk({x_lim_o, x_rdata_o}, {l, e});
        chk({y_lim_o, y_rdata_o}, {l, e});
    endtask
    task automatic t_regs;
        u_core.wr(1'b0, 4'h0, 24'h12_3456);
        rd(4'h0, 24'h12_3456, 1'b0);
        u_core.wr(1'b1, 4'h1, 24'hAB_CDEF);
        u_core.wr(1'b1, 4'h2, 24'h65_4321);
        u_core.wr(1'b0, 4'h3, 24'h0F_0F0F);
        rd(4'h1, 24'hAB_CDEF, 1'b0);
        rd(4'h2, 24'h65_4321, 1'b0);
        rd(4'h3, 24'h0F_0F0F, 1'b0);
        $display("t_regs done");
    endtask
    task automatic t_mac;
        u_core.wr(1'b0, 4'h0, 24'h40_0000);
        u_core.wr(1'b1, 4'h2, 24'h20_0000);
        u_core.op(4'h1, 3'h0, 1'b0, 2'h0, 1'b0, 7'h00, 1'b1);
        u_core.op(4'h2, 3'h0, 1'b0, 2'h0, 1'b0, 7'h00, 1'b0);
        chk({24'h00_0000, res_valid_o}, 25'h000_0001);
        repeat (2) @(negedge clk_i);
        chk({24'h00_0000, res_valid_o}, 25'h000_0000);
        rd(4'h5, 24'h20_0000, 1'b0);
        rd(4'h4, 24'h00_0000, 1'b0);
        rd(4'h6, 24'h00_0000, 1'b0);
        $display("t_mac done");
    endtask
    task automatic t_sign;
        u_core.wr(1'b0, 4'h0, 24'hC0_0000);
        u_core.wr(1'b1, 4'h2, 24'h40_0000);
        u_core.op(4'h1, 3'h0, 1'b1, 2'h0, 1'b0, 7'h00, 1'b0);
        rd(4'h8, 24'hE0_0000, 1'b0);
        rd(4'h7, 24'hFF_FFFF, 1'b0);
        u_core.wr(1'b1, 4'h2, 24'hC0_0000);
        u_core.op(4'h1, 3'h0, 1'b1, 2'h2, 1'b0, 7'h00, 1'b0);
        rd(4'h7, 24'h00_0001, 1'b0);
        u_core.op(4'h1, 3'h0, 1'b1, 2'h1, 1'b0, 7'h00, 1'b0);
        rd(4'h8, 24'hA0_0000, 1'b0);
        u_core.op(4'h1, 3'h0, 1'b1, 2'h0, 1'b0, 7'h00, 1'b0);
        rd(4'h8, 24'h20_0000, 1'b0);
        $display("t_sign done");
    endtask
    task automatic t_round;
        u_core.wr(1'b0, 4'h0, 24'h00_0001);
        u_core.wr(1'b1, 4'h2, 24'h40_0000);
        u_core.op(4'h1, 3'h0, 1'b0, 2'h0, 1'b0, 7'h00, 1'b0);
        rd(4'h6, 24'h80_0000, 1'b0);
        u_core.op(4'h1, 3'h0, 1'b0, 2'h0, 1'b1, 7'h00, 1'b0);
        rd(4'h5, 24'h00_0001, 1'b0);
        rd(4'h6, 24'h00_0000, 1'b0);
        $display("t_round done");
    endtask
    task automatic t_lim;
        u_core.wr(1'b0, 4'h4, 24'h00_0001);
        u_core.wr(1'b0, 4'h5, 24'h12_3456);
        rd(4'hA, 24'h7F_FFFF, 1'b1);
        u_core.wr(1'b1, 4'h4, 24'h00_00FF);
        rd(4'hA, 24'h80_0000, 1'b1);
        u_core.wr(1'b0, 4'h4, 24'h00_0000);
        rd(4'hA, 24'h12_3456, 1'b0);
        $display("t_lim done");
    endtask
    task automatic t_shift;
        u_core.op(4'hA, 3'h6, 1'b1, 2'h0, 1'b0, 7'h04, 1'b0);
        rd(4'h8, 24'h23_4560, 1'b0);
        rd(4'h7, 24'h00_0001, 1'b0);
        u_core.op(4'h9, 3'h7, 1'b0, 2'h0, 1'b0, 7'h78, 1'b0);
        rd(4'h5, 24'h01_2345, 1'b0);
        rd(4'h6, 24'h60_0000, 1'b0);
        $display("t_shift done");
    endtask
    task automatic t_m16;
        u_core.set_mode(1'b1);
        u_core.wr(1'b0, 4'h0, 24'h00_1234);
        rd(4'h0, 24'h00_1234, 1'b0);
        u_core.set_mode(1'b0);
        rd(4'h0, 24'h12_3400, 1'b0);
        $display("t_m16 done");
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        t_regs();
        t_mac();
        t_sign();
        t_round();
        t_lim();
        t_shift();
        t_m16();
        final_report();
    end
    initial begin
        #200000;
        err_count++;
        final_report();
    end
endmodule
